// ==== logic/adcst_pacer.sv ====
// Cascaded two-stage pacer divider feeding conversion triggers.
// Assumes divisors come from the register file; zero means full count.
`timescale 1ns/1ps
module adcst_pacer #(
  parameter int TICK_CYCLES = adcst_pkg::PACER_TICK_CYCLES
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic run,
  input wire logic [15:0] div_first,
  input wire logic [15:0] div_second,
  output logic pulse_r
);
  import adcst_pkg::*;

  logic [15:0] pre_cnt_r;
  logic [15:0] first_cnt_r;
  logic [15:0] second_cnt_r;
  logic tick;
  logic first_out;

  // Prescale the core clock down to the pacer base clock
  assign tick = run && (pre_cnt_r == 16'(TICK_CYCLES - 1));

  always_ff @(posedge core_clk)
  begin
    if (reset || !run || tick)
      pre_cnt_r <= 16'h0000;
    else
      pre_cnt_r <= pre_cnt_r + 16'h0001;
  end

  // First stage; reload on terminal count, cascades into second
  assign first_out = tick && (first_cnt_r == 16'h0001);

  always_ff @(posedge core_clk)
  begin
    if (reset || !run)
      first_cnt_r <= div_first;
    else if (tick)
      first_cnt_r <= (first_cnt_r == 16'h0001) ? div_first : first_cnt_r - 16'h0001;
  end

  // Second stage produces one trigger per full cascade period
  always_ff @(posedge core_clk)
  begin
    if (reset || !run)
    begin
      second_cnt_r <= div_second;
      pulse_r <= 1'b0;
    end
    else
    begin
      pulse_r <= first_out && (second_cnt_r == 16'h0001);
      if (first_out)
        second_cnt_r <= (second_cnt_r == 16'h0001) ? div_second : second_cnt_r - 16'h0001;
    end
  end

endmodule

// ==== logic/adcst_pkg.sv ====
// Package for the acquisition scan and trigger control block.
// Assumes an 8-bit I/O bus with a 4-bit port offset and a 20 MHz core clock.
package adcst_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFF_SAMPLE_LOW = 4'h0;
  localparam logic [3:0] OFF_SAMPLE_HIGH = 4'h1;
  localparam logic [3:0] OFF_SCAN_LIMITS = 4'h2;
  localparam logic [3:0] OFF_STATUS = 4'h8;
  localparam logic [3:0] OFF_CONTROL = 4'h9;
  localparam logic [3:0] OFF_PACER_ENABLE = 4'ha;
  localparam logic [3:0] OFF_TIMER0 = 4'hc;
  localparam logic [3:0] OFF_TIMER1 = 4'hd;
  localparam logic [3:0] OFF_TIMER2 = 4'he;
  localparam logic [3:0] OFF_TIMER_CTRL = 4'hf;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int STAT_BUSY_BIT = 7;
  localparam int STAT_CFG_BIT = 5;
  localparam int STAT_VALID_BIT = 4;
  localparam int CTRL_IRQ_EN_BIT = 7;
  localparam int CTRL_IRQ_LVL_LSB = 4;
  localparam int CTRL_DMA_EN_BIT = 2;
  localparam int CTRL_TRIG_HI_BIT = 1;
  localparam int CTRL_TRIG_LO_BIT = 0;
  localparam int TCW_SEL_LSB = 6;

  // ----------------------------------------------------------------
  // Reset values and DMA bytes per sample
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] SCAN_RESET = 8'h00;
  localparam logic PACER_DISABLE_RESET = 1'b1;
  localparam logic [3:0] RANGE_RESET = 4'h0;
  localparam logic [15:0] TIMER_RESET = 16'h0000;
  localparam logic [1:0] DMA_BYTES_PER_SAMPLE = 2'h2;

  // ----------------------------------------------------------------
  // Timing: pacer input clock period and its cycle count
  // ----------------------------------------------------------------
  localparam int CORE_CLK_PERIOD_NS = 50;
  localparam int PACER_TICK_NS = 100;
  localparam int PACER_TICK_CYCLES_RAW = PACER_TICK_NS / CORE_CLK_PERIOD_NS;
  localparam int PACER_TICK_CYCLES = (PACER_TICK_CYCLES_RAW < 1) ? 1 : PACER_TICK_CYCLES_RAW;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    TRIG_SOFTWARE = 2'b00,
    TRIG_EXTERNAL = 2'b10,
    TRIG_PACER = 2'b11
  } adcst_trig_e;

  typedef enum logic [1:0]
  {
    DMA_IDLE = 2'b00,
    DMA_REQ = 2'b01,
    DMA_GAP = 2'b10
  } adcst_dma_e;

  typedef struct packed
  {
    logic [3:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } adcst_io_req_s;

  typedef struct packed
  {
    logic done;
    logic [11:0] sample_bits;
  } adcst_conv_res_s;

  typedef struct packed
  {
    logic start;
    logic [3:0] channel;
    logic [3:0] range;
  } adcst_conv_cmd_s;

endpackage

// ==== logic/adcst_top.sv ====
// Register file, scan sequencer and trigger control of the acquisition card.
// Assumes a synchronous 8-bit I/O bus, an external converter that answers
// each start with one done pulse, and a system DMA controller with ack/tc.
//
// Behaviour
// - Pacer runs while pacer disable bit is 0, held off when 1.
// - Result low nibble in offset 0 bits 7..4, upper byte at offset 1.
// - Offset 0 bits 3..0 hold source channel of the stored sample.
// - Status: busy bit 7, config bit 5, valid bit 4, next channel 3..0.
// - Strap picks 16 single-ended or 8 differential; status bit reports it.
// - Scan register: start channel bits 3..0, stop channel bits 7..4.
// - Equal start and stop converts that same channel on every trigger.
// - Each conversion advances channel; after stop wraps to start.
// - Any scan register write reloads pointer with new start channel.
// - Range write at offset 1 stored for scan start channel.
// - Per-channel range codes kept and applied on each conversion.
// - Control bits 1..0 select trigger source.
// - Upper bit 0 software, 10 external, 11 pacer.
// - Software mode: any write to offset 0 while not busy starts one conversion.
// - Pacer mode: cascaded counters start conversions periodically.
// - External mode: each rising edge of trigger input while not busy starts conversion while the external trigger strap is set.
// - Busy reads 1 during conversion, 0 when idle.
// - Busy clears itself when conversion finishes.
// - Valid set on completion; cleared by any write to status.
// - With interrupts enabled, request raised at end of conversion (DMA terminal count in DMA mode) on chosen level.
// - Status write withdraws request and re-arms interrupt generation.
// - With DMA enabled each conversion issues two successive DMA requests.
`timescale 1ns/1ps
module adcst_top #(
  parameter int CHANNELS = 16,
  parameter int RANGE_BITS = 4
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire adcst_pkg::adcst_io_req_s io_req,
  output logic [7:0] io_rdata_r,
  input wire logic input_config_strap,
  input wire logic external_trigger_strap,
  input wire logic ext_trigger,
  output adcst_pkg::adcst_conv_cmd_s conv_cmd_r,
  input wire adcst_pkg::adcst_conv_res_s conv_res,
  output logic irq_req_r,
  output logic [2:0] irq_level_field_r,
  output logic dma_req_r,
  input wire logic dma_ack,
  input wire logic dma_tc
);
  import adcst_pkg::*;
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] scan_r, control_r, timer_ctrl_r, rd_mux;
  logic [3:0] next_ch_r, src_ch_r, conv_ch_r, scan_start, scan_stop;
  logic [11:0] sample_bits_r;
  logic pacer_disable_bit_r, busy_r, valid_r, irq_pending_r, cfg_single_r, ext_prev_r;
  logic [RANGE_BITS-1:0] range_mem [CHANNELS];
  logic [15:0] timer_r [3];
  logic [2:0] timer_hi_r;
  adcst_dma_e dma_state_r;
  logic [1:0] dma_left_r, trig_sel;
  logic pacer_pulse, trig_fire, wr_status, wr_scan, conv_done;
  // Strobe decode shared by the processes below
  function automatic logic wr_hit(input adcst_io_req_s r, input logic [3:0] off);
    wr_hit = r.wr && (r.addr == off);
  endfunction
  // Trigger source decode: upper bit low means software regardless of lower
  function automatic adcst_trig_e trig_decode(input logic [1:0] sel);
    if (!sel[1])
      trig_decode = TRIG_SOFTWARE;
    else if (sel[0])
      trig_decode = TRIG_PACER;
    else
      trig_decode = TRIG_EXTERNAL;
  endfunction
  assign wr_status = wr_hit(io_req, OFF_STATUS);
  assign wr_scan = wr_hit(io_req, OFF_SCAN_LIMITS);
  assign conv_done = busy_r && conv_res.done;
  assign trig_sel = {control_r[CTRL_TRIG_HI_BIT], control_r[CTRL_TRIG_LO_BIT]};
  assign scan_start = scan_r[3:0];
  assign scan_stop = scan_r[7:4];
  // ----------------------------------------------------------------
  // Configuration strap and control registers
  // ----------------------------------------------------------------
  // Strap is sampled by the clock, never loaded under reset
  always_ff @(posedge core_clk)
  begin
    cfg_single_r <= input_config_strap;
  end
  // Control register with trigger select, DMA and interrupt fields
  always_ff @(posedge core_clk)
  begin
    if (reset)
      control_r <= CONTROL_RESET;
    else if (wr_hit(io_req, OFF_CONTROL))
      control_r <= io_req.wdata;
  end
  // Pacer disable bit
  always_ff @(posedge core_clk)
  begin
    if (reset)
      pacer_disable_bit_r <= PACER_DISABLE_RESET;
    else if (wr_hit(io_req, OFF_PACER_ENABLE))
      pacer_disable_bit_r <= io_req.wdata[0];
  end
  // Scan limits; software keeps top bits zero in differential mode
  always_ff @(posedge core_clk)
  begin
    if (reset)
      scan_r <= SCAN_RESET;
    else if (wr_scan)
      scan_r <= io_req.wdata;
  end
  // Range code memory addressed by the scan start field
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < CHANNELS; i++)
        range_mem[i] <= RANGE_BITS'(RANGE_RESET);
    end
    else if (wr_hit(io_req, OFF_SAMPLE_HIGH))
      range_mem[scan_start] <= io_req.wdata[RANGE_BITS-1:0];
  end
  // ----------------------------------------------------------------
  // Pacer timer registers; byte pairs alternate low then high
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < 3; i++)
        timer_r[i] <= TIMER_RESET;
      timer_hi_r <= 3'h0;
      timer_ctrl_r <= 8'h00;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (wr_hit(io_req, OFF_TIMER0 + 4'(i)))
        begin
          if (timer_hi_r[i])
            timer_r[i][15:8] <= io_req.wdata;
          else
            timer_r[i][7:0] <= io_req.wdata;
          timer_hi_r[i] <= !timer_hi_r[i];
        end
      end
      // A control word for a counter restarts its byte order
      if (wr_hit(io_req, OFF_TIMER_CTRL))
      begin
        timer_ctrl_r <= io_req.wdata;
        if (io_req.wdata[TCW_SEL_LSB +: 2] != 2'h3)
          timer_hi_r[io_req.wdata[TCW_SEL_LSB +: 2]] <= 1'b0;
      end
    end
  end
  // Counters 1 and 2 cascade into the conversion trigger
  adcst_pacer #(
    .TICK_CYCLES(PACER_TICK_CYCLES)
  ) u_pacer (
    .core_clk(core_clk),
    .reset(reset),
    .run(!pacer_disable_bit_r),
    .div_first(timer_r[1]),
    .div_second(timer_r[2]),
    .pulse_r(pacer_pulse)
  );
  // ----------------------------------------------------------------
  // Trigger selection
  // ----------------------------------------------------------------
  // External input is synchronous; remember it for edge detection
  always_ff @(posedge core_clk)
  begin
    if (reset)
      ext_prev_r <= 1'b0;
    else
      ext_prev_r <= ext_trigger;
  end
  // One trigger event per cycle from the selected source
  always_comb
  begin
    trig_fire = 1'b0;
    case (trig_decode(trig_sel))
      TRIG_SOFTWARE: trig_fire = wr_hit(io_req, OFF_SAMPLE_LOW);
      TRIG_PACER: trig_fire = pacer_pulse;
      TRIG_EXTERNAL: trig_fire = external_trigger_strap && ext_trigger && !ext_prev_r;
      default: trig_fire = 1'b0;
    endcase
  end
  // ----------------------------------------------------------------
  // Conversion sequencing
  // ----------------------------------------------------------------
  // Busy flag; a trigger while busy is ignored
  always_ff @(posedge core_clk)
  begin
    if (reset)
      busy_r <= 1'b0;
    else if (conv_done)
      busy_r <= 1'b0;
    else if (trig_fire)
      busy_r <= 1'b1;
  end
  // Start command with channel and its range code
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      conv_cmd_r <= '0;
      conv_ch_r <= 4'h0;
    end
    else
    begin
      conv_cmd_r.start <= trig_fire && !busy_r;
      if (trig_fire && !busy_r)
      begin
        conv_cmd_r.channel <= next_ch_r;
        conv_cmd_r.range <= 4'(range_mem[next_ch_r]);
        conv_ch_r <= next_ch_r;
      end
    end
  end
  // Channel pointer; a scan write outranks an advance
  always_ff @(posedge core_clk)
  begin
    if (reset)
      next_ch_r <= 4'h0;
    else if (wr_scan)
      next_ch_r <= io_req.wdata[3:0];
    else if (trig_fire && !busy_r)
    begin
      if (next_ch_r == scan_stop)
        next_ch_r <= scan_start;
      else
        next_ch_r <= next_ch_r + 4'h1;
    end
  end
  // Result and source channel update only on completion
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      sample_bits_r <= 12'h000;
      src_ch_r <= 4'h0;
    end
    else if (conv_done)
    begin
      sample_bits_r <= conv_res.sample_bits;
      src_ch_r <= conv_ch_r;
    end
  end
  // Data valid; a completion in the clearing cycle wins
  always_ff @(posedge core_clk)
  begin
    if (reset)
      valid_r <= 1'b0;
    else if (conv_done)
      valid_r <= 1'b1;
    else if (wr_status)
      valid_r <= 1'b0;
  end
  // ----------------------------------------------------------------
  // Interrupt and DMA requests
  // ----------------------------------------------------------------
  // Interrupt source is completion, or DMA terminal count in DMA mode
  always_ff @(posedge core_clk)
  begin
    if (reset)
      irq_pending_r <= 1'b0;
    else if (control_r[CTRL_DMA_EN_BIT] ? dma_tc : conv_done)
      irq_pending_r <= 1'b1;
    else if (wr_status)
      irq_pending_r <= 1'b0;
  end
  // Request line gated by the enable, level carried alongside
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      irq_req_r <= 1'b0;
      irq_level_field_r <= 3'h0;
    end
    else
    begin
      irq_req_r <= irq_pending_r && control_r[CTRL_IRQ_EN_BIT] && !wr_status;
      irq_level_field_r <= control_r[CTRL_IRQ_LVL_LSB +: 3];
    end
  end
  // Two requests per sample, one for each result byte
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      dma_state_r <= DMA_IDLE;
      dma_left_r <= 2'h0;
      dma_req_r <= 1'b0;
    end
    else
    begin
      case (dma_state_r)
        DMA_IDLE:
        begin
          if (conv_done && control_r[CTRL_DMA_EN_BIT])
          begin
            dma_state_r <= DMA_REQ;
            dma_left_r <= DMA_BYTES_PER_SAMPLE;
            dma_req_r <= 1'b1;
          end
        end
        DMA_REQ:
        begin
          if (dma_ack)
          begin
            dma_req_r <= 1'b0;
            dma_left_r <= dma_left_r - 2'h1;
            dma_state_r <= (dma_left_r == 2'h1) ? DMA_IDLE : DMA_GAP;
          end
        end
        DMA_GAP:
        begin
          dma_req_r <= 1'b1;
          dma_state_r <= DMA_REQ;
        end
        default:
        begin
          dma_state_r <= DMA_IDLE;
          dma_req_r <= 1'b0;
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Read path; reads change no state
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_mux = 8'h00;
    case (io_req.addr)
      OFF_SAMPLE_LOW: rd_mux = {sample_bits_r[3:0], src_ch_r};
      OFF_SAMPLE_HIGH: rd_mux = sample_bits_r[11:4];
      OFF_SCAN_LIMITS: rd_mux = scan_r;
      OFF_STATUS: rd_mux = {busy_r, 1'b0, cfg_single_r, valid_r, next_ch_r};
      OFF_CONTROL: rd_mux = control_r;
      OFF_PACER_ENABLE: rd_mux = {7'h00, pacer_disable_bit_r};
      OFF_TIMER0: rd_mux = timer_hi_r[0] ? timer_r[0][15:8] : timer_r[0][7:0];
      OFF_TIMER1: rd_mux = timer_hi_r[1] ? timer_r[1][15:8] : timer_r[1][7:0];
      OFF_TIMER2: rd_mux = timer_hi_r[2] ? timer_r[2][15:8] : timer_r[2][7:0];
      OFF_TIMER_CTRL: rd_mux = timer_ctrl_r;
      default: rd_mux = 8'h00;
    endcase
  end
  // Read data registered on the read strobe
  always_ff @(posedge core_clk)
  begin
    if (reset)
      io_rdata_r <= 8'h00;
    else if (io_req.rd)
      io_rdata_r <= rd_mux;
  end
endmodule

// ==== sim/adc_scan_trigger_control_tb.sv ====
// Testbench for the scan and trigger control block.
// Assumes the far side model answers conversions and DMA requests.
`timescale 1ns/1ps
module adc_scan_trigger_control_tb;
  import adcst_pkg::*;
  logic core_clk;
  logic reset;
  adcst_io_req_s io_req;
  logic [7:0] io_rdata_r;
  logic strap;
  logic xs;
  logic ext_trigger;
  adcst_conv_cmd_s conv_cmd_r;
  adcst_conv_res_s conv_res;
  logic irq_req_r;
  logic [2:0] irq_level_field_r;
  logic dma_req_r;
  logic dma_ack;
  logic dma_tc;
  logic rd_q;
  logic prev_req;
  logic [15:0] e;
  logic [15:0] rd_exp_q[$];
  logic [7:0] cmd_exp_q[$];
  logic [3:0] rng[16];
  logic [3:0] ptr;
  logic [3:0] lo;
  logic [3:0] hi;
  int n_errors;
  int tests_run;
  int n_starts;
  int cyc;
  int t_last;
  int ival;
  int k;

  adcst_top dut_u
  (
    .core_clk(core_clk), .reset(reset), .io_req(io_req), .io_rdata_r(io_rdata_r),
    .input_config_strap(strap), .external_trigger_strap(xs), .ext_trigger(ext_trigger),
    .conv_cmd_r(conv_cmd_r), .conv_res(conv_res), .irq_req_r(irq_req_r),
    .irq_level_field_r(irq_level_field_r), .dma_req_r(dma_req_r), .dma_ack(dma_ack),
    .dma_tc(dma_tc)
  );
  adcst_conv_model far_u
  (
    .core_clk(core_clk), .reset(reset), .conv_cmd_r(conv_cmd_r), .dma_req_r(dma_req_r),
    .conv_res(conv_res), .dma_ack(dma_ack), .dma_tc(dma_tc)
  );

  // --------
  // Helpers
  // --------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("errors %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d);
    @(posedge core_clk);
    io_req <= '{addr: a, wr: w, rd: !w, wdata: d};
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] v);
    rd_exp_q.push_back({m, v & m});
    bus(a, 1'b0, 8'h00);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk) io_req <= '0;
  endtask
  task automatic scan(input logic [3:0] s, input logic [3:0] t);
    lo = s;
    hi = t;
    ptr = s;
    bus(OFF_SCAN_LIMITS, 1'b1, {t, s});
  endtask
  task automatic note();
    cmd_exp_q.push_back({ptr, rng[ptr]});
    ptr = (ptr == hi) ? lo : ptr + 4'h1;
  endtask
  task automatic trig();
    note();
    bus(OFF_SAMPLE_LOW, 1'b1, 8'($urandom));
  endtask
  task automatic wait_done();
    for (int i = 0; i < 40; i++)
    begin
      @(posedge core_clk);
      io_req <= '0;
      if (conv_res.done === 1'b1)
        break;
    end
  endtask
  task automatic irq_chk(input logic v);
    idle(2);
    @(negedge core_clk);
    chk({7'h00, irq_req_r}, {7'h00, v});
  endtask
  task automatic pulse();
    @(posedge core_clk) ext_trigger <= 1'b1;
    @(posedge core_clk) ext_trigger <= 1'b0;
  endtask
  // Polled software conversion with full readout
  task automatic conv_sw();
    logic [3:0] c;
    c = ptr;
    trig();
    rd(OFF_STATUS, 8'h80, 8'h80);
    wait_done();
    rd(OFF_STATUS, 8'hff, {2'b00, strap, 1'b1, ptr});
    rd(OFF_SAMPLE_LOW, 8'hff, {c ^ 4'h5, c});
    rd(OFF_SAMPLE_HIGH, 8'hff, {c, rng[c]});
    rd(OFF_SAMPLE_LOW, 8'hff, {c ^ 4'h5, c});
    bus(OFF_STATUS, 1'b1, 8'h00);
    rd(OFF_STATUS, 8'h10, 8'h00);
    idle(2);
  endtask

  // --------
  // Clock, monitor and watchdog
  // --------
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    rd_q <= io_req.rd && !reset;
    cyc <= cyc + 1;
  end
  // Compare each result with the oldest note
  always @(negedge core_clk)
  begin
    if (rd_q)
    begin
      e = rd_exp_q.pop_front();
      chk(io_rdata_r & e[15:8], e[7:0]);
    end
    if (conv_cmd_r.start === 1'b1)
    begin
      n_starts++;
      ival = cyc - t_last;
      t_last = cyc;
      if (cmd_exp_q.size() == 0)
        chk(8'hff, 8'h00);
      else
        chk({conv_cmd_r.channel, conv_cmd_r.range}, cmd_exp_q.pop_front());
    end
  end
  initial
  begin
    repeat (30000) @(posedge core_clk);
    n_errors++;
    end_sim();
  end

  // --------
  // Main sequence
  // --------
  initial
  begin
    io_req = '0;
    strap = 1'b1;
    xs = 1'b1;
    ext_trigger = 1'b0;
    reset = 1'b1;
    n_errors = 0;
    tests_run = 0;
    cyc = 0;
    t_last = 0;
    k = $urandom(33);
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    rd(OFF_CONTROL, 8'hff, CONTROL_RESET);
    rd(OFF_SCAN_LIMITS, 8'hff, SCAN_RESET);
    rd(OFF_PACER_ENABLE, 8'h01, 8'h01);
    rd(OFF_STATUS, 8'hff, 8'h20);
    rd(4'hb, 8'hff, 8'h00);
    strap <= 1'b0;
    idle(2);
    rd(OFF_STATUS, 8'h20, 8'h00);
    strap <= 1'b1;
    idle(2);
    for (int c = 0; c < 16; c++)
    begin
      rng[c] = 4'($urandom);
      scan(4'(c), 4'(c));
      bus(OFF_SAMPLE_HIGH, 1'b1, {4'h0, rng[c]});
    end
    scan(4'h3, 4'h6);
    rd(OFF_SCAN_LIMITS, 8'hff, 8'h63);
    repeat (6) conv_sw();
    strap <= 1'b0;
    scan(4'h7, 4'h7);
    repeat (2) conv_sw();
    strap <= 1'b1;
    bus(OFF_CONTROL, 1'b1, 8'h01);
    trig();
    bus(OFF_SAMPLE_LOW, 1'b1, 8'h5a);
    wait_done();
    bus(OFF_CONTROL, 1'b1, 8'h02);
    bus(OFF_SAMPLE_LOW, 1'b1, 8'ha5);
    xs <= 1'b0;
    idle(1);
    pulse();
    idle(30);
    xs <= 1'b1;
    note();
    pulse();
    wait_done();
    bus(OFF_STATUS, 1'b1, 8'h00);
    bus(OFF_TIMER_CTRL, 1'b1, 8'h40);
    bus(OFF_TIMER1, 1'b1, 8'h02);
    bus(OFF_TIMER1, 1'b1, 8'h00);
    rd(OFF_TIMER1, 8'hff, 8'h02);
    bus(OFF_TIMER_CTRL, 1'b1, 8'h80);
    bus(OFF_TIMER2, 1'b1, 8'h14);
    bus(OFF_TIMER2, 1'b1, 8'h00);
    bus(OFF_CONTROL, 1'b1, 8'h03);
    scan(4'h0, 4'h2);
    repeat (3) note();
    n_starts = 0;
    bus(OFF_PACER_ENABLE, 1'b1, 8'h00);
    for (int i = 0; i < 400 && n_starts < 3; i++)
      idle(1);
    bus(OFF_PACER_ENABLE, 1'b1, 8'h01);
    chk(8'(ival), 8'h50);
    idle(200);
    bus(OFF_STATUS, 1'b1, 8'h00);
    for (int l = 0; l < 8; l++)
    begin
      bus(OFF_CONTROL, 1'b1, {1'b1, 3'(l), 4'h0});
      idle(2);
      @(negedge core_clk);
      chk({5'h00, irq_level_field_r}, 8'(l));
    end
    trig();
    wait_done();
    irq_chk(1'b1);
    bus(OFF_STATUS, 1'b1, 8'h00);
    irq_chk(1'b0);
    bus(OFF_CONTROL, 1'b1, 8'h70);
    trig();
    wait_done();
    irq_chk(1'b0);
    bus(OFF_STATUS, 1'b1, 8'h00);
    bus(OFF_CONTROL, 1'b1, 8'h84);
    trig();
    k = 0;
    prev_req = 1'b0;
    for (int i = 0; i < 80; i++)
    begin
      idle(1);
      if (dma_req_r === 1'b1 && prev_req === 1'b0)
        k++;
      prev_req = dma_req_r;
    end
    chk(8'(k), 8'h02);
    irq_chk(1'b1);
    bus(OFF_STATUS, 1'b1, 8'h00);
    irq_chk(1'b0);
    end_sim();
  end
endmodule

// ==== sim/adcst_conv_model.sv ====
// Far side model: converter answering each start, and a DMA controller.
// Assumes start is a one-cycle pulse and the request drops after ack.
`timescale 1ns/1ps
module adcst_conv_model
(
  input wire logic core_clk,
  input wire logic reset,
  input wire adcst_pkg::adcst_conv_cmd_s conv_cmd_r,
  input wire logic dma_req_r,
  output adcst_pkg::adcst_conv_res_s conv_res,
  output logic dma_ack,
  output logic dma_tc
);
  import adcst_pkg::*;
  logic [4:0] cnt_r;
  logic [7:0] held_r;
  logic [1:0] ack_cnt_r;
  logic odd_r;
  // Converter: done after 3 + channel cycles, data toggles otherwise
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      cnt_r <= 5'h00;
      held_r <= 8'h00;
      conv_res <= '0;
    end
    else
    begin
      conv_res.done <= 1'b0;
      conv_res.sample_bits <= ~conv_res.sample_bits;
      if (conv_cmd_r.start)
      begin
        cnt_r <= 5'h03 + 5'(conv_cmd_r.channel);
        held_r <= {conv_cmd_r.channel, conv_cmd_r.range};
      end
      else if (cnt_r != 5'h00)
      begin
        cnt_r <= cnt_r - 5'h01;
        if (cnt_r == 5'h01)
        begin
          conv_res.done <= 1'b1;
          conv_res.sample_bits <= {held_r, held_r[7:4] ^ 4'h5};
        end
      end
    end
  end
  // DMA: ack each request after two cycles, terminal count every second
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ack_cnt_r <= 2'h0;
      dma_ack <= 1'b0;
      dma_tc <= 1'b0;
      odd_r <= 1'b0;
    end
    else
    begin
      dma_ack <= 1'b0;
      dma_tc <= 1'b0;
      if (dma_ack)
        ack_cnt_r <= 2'h0;
      else if (dma_req_r)
      begin
        ack_cnt_r <= ack_cnt_r + 2'h1;
        if (ack_cnt_r == 2'h1)
        begin
          dma_ack <= 1'b1;
          dma_tc <= odd_r;
          odd_r <= !odd_r;
        end
      end
    end
  end
endmodule

// ==== sim/adcst_props.sv ====
// Checker for the scan and trigger control block.
// Assumes it sees only the ports of the top module, through bind.
`timescale 1ns/1ps
module adcst_props
(
  input wire logic core_clk,
  input wire logic reset,
  input wire adcst_pkg::adcst_io_req_s io_req,
  input wire logic [7:0] io_rdata_r,
  input wire logic input_config_strap,
  input wire adcst_pkg::adcst_conv_cmd_s conv_cmd_r,
  input wire adcst_pkg::adcst_conv_res_s conv_res,
  input wire logic irq_req_r,
  input wire logic [2:0] irq_level_field_r,
  input wire logic dma_req_r,
  input wire logic dma_ack,
  input wire logic dma_tc
);
  import adcst_pkg::*;
  // --------
  // Properties
  // --------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  a_start_pulse: assert property (
    conv_cmd_r.start |=> !conv_cmd_r.start) else $error("start longer than one cycle");
  a_cmd_hold: assert property (
    !conv_cmd_r.start |-> $stable({conv_cmd_r.channel, conv_cmd_r.range}))
    else $error("command changed without start");
  a_rdata_hold: assert property (
    !io_req.rd |=> $stable(io_rdata_r)) else $error("read data changed without read");
  a_unmapped_zero: assert property (
    io_req.rd && io_req.addr inside {4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hb}
    |=> io_rdata_r == 8'h00) else $error("unmapped read not zero");
  a_status_cfg: assert property (
    io_req.rd && io_req.addr == OFF_STATUS && $stable(input_config_strap)
    |=> io_rdata_r[STAT_CFG_BIT] == $past(input_config_strap) && !io_rdata_r[6])
    else $error("status config bit wrong");
  a_busy_read: assert property (
    conv_cmd_r.start && io_req.rd && io_req.addr == OFF_STATUS
    |=> io_rdata_r[STAT_BUSY_BIT]) else $error("busy not shown");
  a_irq_level: assert property (
    (io_req.wr && io_req.addr == OFF_CONTROL) ##1 !(io_req.wr && io_req.addr == OFF_CONTROL)
    |=> irq_level_field_r == $past(io_req.wdata[6:4], 2)) else $error("irq level wrong");
  a_irq_drop: assert property (
    (io_req.wr && io_req.addr == OFF_STATUS && !conv_res.done && !dma_tc)
    ##1 (!conv_res.done && !dma_tc) |=> !irq_req_r) else $error("irq not withdrawn");
  a_dma_drop: assert property (
    dma_req_r && dma_ack |=> !dma_req_r) else $error("dma request held after ack");
endmodule

bind adcst_top adcst_props adcst_props_u
(
  .core_clk(core_clk), .reset(reset), .io_req(io_req), .io_rdata_r(io_rdata_r),
  .input_config_strap(input_config_strap), .conv_cmd_r(conv_cmd_r),
  .conv_res(conv_res), .irq_req_r(irq_req_r), .irq_level_field_r(irq_level_field_r),
  .dma_req_r(dma_req_r), .dma_ack(dma_ack), .dma_tc(dma_tc)
);
